//--- hdl/scs_pkg.sv
// Package: constants, register map and bus carrier for the smart-card serial channel
package scs_pkg;

  // ****************************************
  // Register map (byte offsets on the plain port)
  // ****************************************
  localparam logic [2:0] SCS_MODE_OFS = 3'h0;
  localparam logic [2:0] SCS_BRG_OFS = 3'h1;
  localparam logic [2:0] SCS_CTL0_OFS = 3'h2;
  localparam logic [2:0] SCS_CTL1_OFS = 3'h3;
  localparam logic [2:0] SCS_TXBUF_OFS = 3'h4;
  localparam logic [2:0] SCS_RXBUF_OFS = 3'h5;
  localparam logic [2:0] SCS_STAT_OFS = 3'h6;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SCS_MODE_STOP2_BIT = 4;
  localparam int SCS_MODE_EVEN_BIT = 5;
  localparam int SCS_MODE_PAREN_BIT = 6;
  localparam int SCS_CTL0_CTSDIS_BIT = 4;
  localparam int SCS_CTL0_MSBF_BIT = 7;
  localparam int SCS_CTL1_TE_BIT = 0;
  localparam int SCS_CTL1_TBE_BIT = 1;
  localparam int SCS_CTL1_RE_BIT = 2;
  localparam int SCS_CTL1_TXSRC_BIT = 4;
  localparam int SCS_CTL1_INV_BIT = 6;
  localparam int SCS_CTL1_ERRSIG_BIT = 7;
  localparam int SCS_STAT_OVR_BIT = 0;
  localparam int SCS_STAT_FER_BIT = 1;
  localparam int SCS_STAT_PER_BIT = 2;
  localparam int SCS_STAT_TXERR_BIT = 4;
  localparam int SCS_STAT_TXIRQ_BIT = 5;
  localparam int SCS_STAT_RXIRQ_BIT = 6;

  // ****************************************
  // Reset values and encodings
  // ****************************************
  localparam logic [2:0] SCS_MODE_UART8 = 3'h5;
  localparam logic [7:0] SCS_MODE_RST = 8'h00;
  localparam logic [7:0] SCS_BRG_RST = 8'h00;
  localparam logic [7:0] SCS_CTL0_RST = 8'h00;
  localparam logic [7:0] SCS_CTL1_RST = 8'h00;
  localparam logic [1:0] SCS_SRC_DIV1 = 2'h0;
  localparam logic [1:0] SCS_SRC_DIV8 = 2'h1;
  localparam logic [2:0] SCS_DIV8_LAST = 3'h7;
  localparam logic [4:0] SCS_DIV32_LAST = 5'h1F;

  // ****************************************
  // Timing counts in oversampling ticks, and bit indices within a frame
  // ****************************************
  localparam logic [3:0] SCS_TICK_LAST = 4'hF;
  localparam logic [3:0] SCS_TICK_MID = 4'h7;
  localparam logic [3:0] SCS_TICK_HALF = 4'h7;
  localparam logic [4:0] SCS_ERR_TICKS = 5'h10;
  localparam logic [3:0] SCS_BIT_STOP_PAR = 4'hA;
  localparam logic [3:0] SCS_BIT_STOP_NOPAR = 4'h9;
  localparam logic [3:0] SCS_BIT_PARITY = 4'h9;

  // Register port request
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } scs_bus_req_t;

endpackage

//--- hdl/scs_sync.sv
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/10ps
module scs_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

//--- hdl/scs_uart.sv
// Smart-card asynchronous serial channel: register port, baud generator, transmitter, receiver
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
module scs_uart
  import scs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire scs_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic tx_irq,
  output logic rx_irq
);

  typedef enum logic [1:0] {SCS_TX_IDLE, SCS_TX_SHIFT, SCS_TX_TAIL} scs_tx_st_t;
  typedef enum logic {SCS_RX_IDLE, SCS_RX_SHIFT} scs_rx_st_t;

  logic [7:0] mode_q, brg_q, ctl0_q, ctl1_q;
  logic [1:0] src_sel_q;
  logic [7:0] tx_buf_q, rx_buf_q, rx_sh_q;
  logic tbe_q, rx_full_q, ovr_q, fer_q, per_q, tx_err_q;
  logic tx_irq_q, rx_irq_q;
  logic [4:0] pre_cnt_q;
  logic [7:0] brg_cnt_q;
  logic pre_en, tick;
  logic rx_s;
  scs_tx_st_t tx_st_q;
  scs_rx_st_t rx_st_q;
  logic [10:0] tx_frame_q;
  logic [3:0] tx_bit_q, tx_ph_q, rx_bit_q, rx_ph_q;
  logic tx_line_q, rx_perr_q, err_act_q;
  logic [4:0] err_cnt_q;
  logic chan_on, tx_en, rx_en, par_en, par_even, msb_first, inv, errsig;
  logic tx_load, tx_done, rx_done, rx_fer_now, tx_busy, rx_busy, tx_in_tail;
  logic [3:0] last_bit;
  logic [7:0] tx_data_ord;
  logic stat_wr;

  // ****************************************
  // Configuration decode
  // ****************************************
  assign chan_on = (mode_q[2:0] == SCS_MODE_UART8);
  assign par_en = mode_q[SCS_MODE_PAREN_BIT];
  assign par_even = mode_q[SCS_MODE_EVEN_BIT];
  assign msb_first = ctl0_q[SCS_CTL0_MSBF_BIT];
  assign inv = ctl1_q[SCS_CTL1_INV_BIT];
  assign errsig = ctl1_q[SCS_CTL1_ERRSIG_BIT];
  assign tx_en = chan_on && ctl1_q[SCS_CTL1_TE_BIT];
  assign rx_en = chan_on && ctl1_q[SCS_CTL1_RE_BIT];
  // One stop bit always; the stop-count bit is stored but never lengthens a frame
  assign last_bit = par_en ? SCS_BIT_STOP_PAR : SCS_BIT_STOP_NOPAR;
  assign stat_wr = bus_req.wr && (bus_req.addr == SCS_STAT_OFS);

  // Input pin reaches logic only through two flops
  scs_sync #(.RST_VAL(1'b1)) u_rx_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(serial_in_pin),
    .sync_out(rx_s)
  );

  // ****************************************
  // Register port
  // ****************************************
  // Configuration writes; transfer clock is always internal, so no external clock path exists
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_q <= SCS_MODE_RST;
      brg_q <= SCS_BRG_RST;
      ctl0_q <= SCS_CTL0_RST;
      ctl1_q <= SCS_CTL1_RST;
    end else if (bus_req.wr) begin
      unique case (bus_req.addr)
        SCS_MODE_OFS: mode_q <= bus_req.wdata;
        SCS_BRG_OFS: brg_q <= bus_req.wdata;
        SCS_CTL0_OFS: ctl0_q <= bus_req.wdata;
        SCS_CTL1_OFS: ctl1_q <= bus_req.wdata;
        default: ;
      endcase
    end
  end

  // Prescaler select rides in the low bits of control 0
  assign src_sel_q = ctl0_q[1:0];

  // Read data registered, valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        SCS_MODE_OFS: bus_rdata <= mode_q;
        SCS_BRG_OFS: bus_rdata <= brg_q;
        SCS_CTL0_OFS: bus_rdata <= ctl0_q;
        SCS_CTL1_OFS: bus_rdata <= {ctl1_q[7:2], tbe_q, ctl1_q[0]};
        SCS_RXBUF_OFS: bus_rdata <= inv ? ~rx_buf_q : rx_buf_q;
        SCS_STAT_OFS: bus_rdata <= {rx_s, rx_irq_q, tx_irq_q, tx_err_q,
                                    (ovr_q | fer_q | per_q), per_q, fer_q, ovr_q};
        default: bus_rdata <= 8'h00;
      endcase
    end else begin
      bus_rdata <= 8'h00;
    end
  end

  // Transmit buffer; inversion is applied as the byte is written
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_buf_q <= 8'h00;
      tbe_q <= 1'b1;
    end else if (bus_req.wr && bus_req.addr == SCS_TXBUF_OFS) begin
      tx_buf_q <= inv ? ~bus_req.wdata : bus_req.wdata;
      tbe_q <= 1'b0;
    end else if (tx_load) begin
      tbe_q <= 1'b1;
    end
  end

  // ****************************************
  // Baud generator
  // ****************************************
  // Prescaled source as an enable: every clock, every 8th or every 32nd
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_cnt_q <= 5'h00;
    end else begin
      pre_cnt_q <= pre_cnt_q + 5'h01;
    end
  end

  always_comb begin
    if (src_sel_q == SCS_SRC_DIV1) begin
      pre_en = 1'b1;
    end else if (src_sel_q == SCS_SRC_DIV8) begin
      pre_en = (pre_cnt_q[2:0] == SCS_DIV8_LAST);
    end else begin
      pre_en = (pre_cnt_q == SCS_DIV32_LAST);
    end
  end

  // Divide by n+1 gives the 16x tick; sixteen ticks make one bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      brg_cnt_q <= 8'h00;
    end else if (pre_en) begin
      brg_cnt_q <= (brg_cnt_q == 8'h00) ? brg_q : brg_cnt_q - 8'h01;
    end
  end
  assign tick = pre_en && (brg_cnt_q == 8'h00);

  // ****************************************
  // Transmitter
  // ****************************************
  assign tx_load = (tx_st_q == SCS_TX_IDLE) && tx_en && !tbe_q;
  // Bit reversal written out, so no streaming operator sits inside the select
  assign tx_data_ord = msb_first ? {tx_buf_q[0], tx_buf_q[1], tx_buf_q[2], tx_buf_q[3],
                                    tx_buf_q[4], tx_buf_q[5], tx_buf_q[6], tx_buf_q[7]} : tx_buf_q;
  assign tx_busy = (tx_st_q != SCS_TX_IDLE);
  assign tx_in_tail = (tx_st_q == SCS_TX_TAIL);
  // Completion at end of stop bit, or half a bit later when error signalling is on
  assign tx_done = tick && (((tx_st_q == SCS_TX_SHIFT) && (tx_bit_q == last_bit) &&
                   (tx_ph_q == SCS_TICK_LAST) && !errsig) ||
                   (tx_in_tail && (tx_ph_q == SCS_TICK_HALF)));

  // Frame is stop, parity, data, start shifted out LSB first
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_st_q <= SCS_TX_IDLE;
      tx_frame_q <= 11'h7FF;
      tx_bit_q <= 4'h0;
      tx_ph_q <= 4'h0;
    end else begin
      unique case (tx_st_q)
        SCS_TX_IDLE: begin
          if (tx_load) begin
            tx_st_q <= SCS_TX_SHIFT;
            tx_frame_q <= {1'b1, (par_even ? ^tx_buf_q : ~^tx_buf_q), tx_data_ord, 1'b0};
            tx_bit_q <= 4'h0;
            tx_ph_q <= 4'h0;
          end
        end
        SCS_TX_SHIFT: begin
          if (tick) begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == SCS_TICK_LAST) begin
              if (tx_bit_q == last_bit) begin
                tx_st_q <= errsig ? SCS_TX_TAIL : SCS_TX_IDLE;
              end else begin
                tx_bit_q <= tx_bit_q + 4'h1;
                tx_frame_q <= {1'b1, tx_frame_q[10:1]};
              end
            end
          end
        end
        SCS_TX_TAIL: begin
          if (tick) begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == SCS_TICK_HALF) begin
              tx_st_q <= SCS_TX_IDLE;
            end
          end
        end
        default: tx_st_q <= SCS_TX_IDLE;
      endcase
    end
  end

  // Line high whenever idle or in the tail; the tail leaves the card room to answer
  assign tx_line_q = (tx_st_q == SCS_TX_SHIFT) ? tx_frame_q[0] : 1'b1;

  // ****************************************
  // Receiver
  // ****************************************
  // Start is refused while our own error pulse holds the shared line low
  assign rx_busy = (rx_st_q == SCS_RX_SHIFT);
  assign rx_done = rx_busy && tick && (rx_ph_q == SCS_TICK_MID) && (rx_bit_q == last_bit);
  assign rx_fer_now = rx_done && !rx_s && !err_act_q;

  // Mid-bit sampling at tick 7; every character is kept, MSB is not inspected
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_st_q <= SCS_RX_IDLE;
      rx_sh_q <= 8'h00;
      rx_bit_q <= 4'h0;
      rx_ph_q <= 4'h0;
      rx_perr_q <= 1'b0;
    end else begin
      unique case (rx_st_q)
        SCS_RX_IDLE: begin
          if (rx_en && !rx_s && !err_act_q) begin
            rx_st_q <= SCS_RX_SHIFT;
            rx_bit_q <= 4'h0;
            rx_ph_q <= 4'h0;
            rx_perr_q <= 1'b0;
          end
        end
        SCS_RX_SHIFT: begin
          if (tick) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == SCS_TICK_MID) begin
              if (rx_bit_q == 4'h0 && rx_s) begin
                rx_st_q <= SCS_RX_IDLE; // Glitch, not a start bit
              end else if (rx_bit_q == last_bit) begin
                rx_st_q <= SCS_RX_IDLE;
              end else if (par_en && rx_bit_q == SCS_BIT_PARITY) begin
                rx_perr_q <= (^{rx_sh_q, rx_s}) ^ ~par_even;
              end else if (rx_bit_q != 4'h0) begin
                rx_sh_q <= msb_first ? {rx_sh_q[6:0], rx_s} : {rx_s, rx_sh_q[7:1]};
              end
            end
            if (rx_ph_q == SCS_TICK_LAST) begin
              rx_bit_q <= rx_bit_q + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Receive buffer and full flag; a read of the buffer empties it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_buf_q <= 8'h00;
      rx_full_q <= 1'b0;
    end else if (rx_done) begin
      rx_buf_q <= rx_sh_q;
      rx_full_q <= 1'b1;
    end else if (bus_req.rd && bus_req.addr == SCS_RXBUF_OFS) begin
      rx_full_q <= 1'b0;
    end
  end

  // Error pulse: from the stop-bit slot for one bit period, then line released
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      err_act_q <= 1'b0;
      err_cnt_q <= 5'h00;
    end else if (rx_busy && tick && rx_ph_q == SCS_TICK_LAST && par_en &&
                 rx_bit_q == SCS_BIT_PARITY && rx_perr_q && errsig) begin
      err_act_q <= 1'b1;
      err_cnt_q <= SCS_ERR_TICKS;
    end else if (err_act_q && tick) begin
      err_cnt_q <= err_cnt_q - 5'h01;
      if (err_cnt_q == 5'h01) begin
        err_act_q <= 1'b0;
      end
    end
  end

  // Output pin registered so it never glitches on the shared line
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      serial_out_pin <= 1'b1;
    end else begin
      serial_out_pin <= tx_line_q && !err_act_q;
    end
  end

  // ****************************************
  // Flags and requests (set wins over write-one-to-clear)
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ovr_q <= 1'b0;
      fer_q <= 1'b0;
      per_q <= 1'b0;
      tx_err_q <= 1'b0;
      tx_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
    end else begin
      ovr_q <= (rx_done && rx_full_q) || (ovr_q && !(stat_wr && bus_req.wdata[SCS_STAT_OVR_BIT]));
      fer_q <= rx_fer_now || (fer_q && !(stat_wr && bus_req.wdata[SCS_STAT_FER_BIT]));
      per_q <= (rx_done && rx_perr_q) || (per_q && !(stat_wr && bus_req.wdata[SCS_STAT_PER_BIT]));
      // Card reports a parity error by holding our input low at completion
      tx_err_q <= (tx_done && !rx_s) || (tx_err_q && !(stat_wr && bus_req.wdata[SCS_STAT_TXERR_BIT]));
      tx_irq_q <= tx_done || (tx_irq_q && !(stat_wr && bus_req.wdata[SCS_STAT_TXIRQ_BIT]));
      // Overrun does not touch the receive request
      rx_irq_q <= (rx_done && !rx_full_q) ||
                  (rx_irq_q && !(stat_wr && bus_req.wdata[SCS_STAT_RXIRQ_BIT]));
    end
  end

  assign tx_irq = tx_irq_q;
  assign rx_irq = rx_irq_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking scs_cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  tx_start_a: assert property ($rose(tx_busy) |-> $past(tx_en) && $past(tbe_q) == 1'b0)
    else $error("transmit started without enable or data");
  rx_start_a: assert property ($rose(rx_busy) |-> $past(rx_en) && !$past(rx_s))
    else $error("receive started without enable or start bit");
  tx_irq_a: assert property (tx_done |=> tx_irq_q ##0 !tx_busy)
    else $error("transmit request missing after completion");
  rx_irq_a: assert property ((rx_done && !rx_full_q) |=> rx_irq_q && rx_full_q)
    else $error("receive request missing after buffer load");
  overrun_a: assert property ((rx_done && rx_full_q && !stat_wr) |=> ovr_q && $stable(rx_irq_q))
    else $error("overrun handled wrongly");
  err_pin_a: assert property ($rose(err_act_q) |-> $past(errsig) ##1 !serial_out_pin [*8])
    else $error("error pulse not on output pin");
  late_done_a: assert property ((tx_done && errsig) |-> tx_in_tail ##1 !tx_busy)
    else $error("completion not delayed by half bit");
  frame_err_a: assert property (rx_fer_now |=> fer_q)
    else $error("framing error not flagged");
  err_sum_a: assert property ((bus_req.rd && (bus_req.addr == SCS_STAT_OFS) && (ovr_q || fer_q || per_q))
                              |=> bus_rdata[3])
    else $error("error sum not reported");

  tx_done_c: cover property (tx_done && errsig);
  rx_perr_c: cover property (rx_done && rx_perr_q);
  overrun_c: cover property (rx_done && rx_full_q);

endmodule

//--- sim/scs_card.sv
// Behavioural smart card sharing the pulled-up data line with the channel
`timescale 1ns/10ps
module scs_card (
  input wire logic clk_sys,
  input wire logic line,
  output logic drive_low
);
  int bit_len;
  int rx_cnt;
  logic nak_en;
  logic bad_stop;
  logic busy;
  logic err_seen;
  logic [8:0] rx_bits;

  // Card starts released; the pull-up holds the line high between frames
  initial begin
    bit_len = 16;
    rx_cnt = 0;
    nak_en = 1'b0;
    bad_stop = 1'b0;
    busy = 1'b0;
    err_seen = 1'b0;
    rx_bits = '0;
    drive_low = 1'b0;
  end

  // ****************************************
  // Card to channel: start, 8 data and parity as given, then release for stop
  // ****************************************
  task automatic send_char(input logic [8:0] bits);
    logic [9:0] f;
    f = {bits, 1'b0};
    busy = 1'b1;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_sys);
      drive_low <= !f[i];
      repeat (bit_len - 1) @(posedge clk_sys);
    end
    // Stop slot released, or held low for a framing error; let go before the slot ends
    @(posedge clk_sys);
    drive_low <= bad_stop;
    repeat (bit_len / 2) @(posedge clk_sys);
    err_seen = !line;
    repeat (bit_len / 4) @(posedge clk_sys);
    drive_low <= 1'b0;
    // Long guard so the channel's own error pulse is not taken as a new start
    repeat (bit_len * 2) @(posedge clk_sys);
    busy = 1'b0;
  endtask

  // ****************************************
  // Channel to card: sample mid-bit, optionally signal a parity error
  // ****************************************
  always begin
    @(negedge line);
    if (!busy) begin
      repeat (bit_len / 2) @(posedge clk_sys);
      for (int i = 0; i < 9; i++) begin
        repeat (bit_len) @(posedge clk_sys);
        rx_bits[i] = line;
      end
      rx_cnt++;
      repeat (bit_len) @(posedge clk_sys);
      // Low from mid stop for two bits, so it spans the sender's late completion point
      if (nak_en) begin
        drive_low <= 1'b1;
        repeat (bit_len * 2) @(posedge clk_sys);
        drive_low <= 1'b0;
      end
      repeat (bit_len) @(posedge clk_sys);
    end
  end
endmodule

//--- sim/tb_smart_card_async_serial_mode.sv
// Self-checking testbench for the smart-card serial channel
`timescale 1ns/10ps
module tb_smart_card_async_serial_mode;
  import scs_pkg::*;
  logic clk_sys;
  logic resetn;
  scs_bus_req_t req;
  logic [7:0] bus_rdata;
  logic serial_out_pin;
  logic tx_irq;
  logic rx_irq;
  logic drive_low;
  logic line;
  int error_cnt;
  int comparisons;
  int t_plain;
  int t_err;
  logic [7:0] s;

  // Open-drain card and pulled-up wire: low wins
  assign line = serial_out_pin & !drive_low;

  scs_uart u_scs_uart (.clk_sys(clk_sys), .resetn(resetn), .bus_req(req), .bus_rdata(bus_rdata),
    .serial_in_pin(line), .serial_out_pin(serial_out_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));
  scs_card u_scs_card (.clk_sys(clk_sys), .line(line), .drive_low(drive_low));

  // 125 MHz
  always #4 clk_sys = !clk_sys;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1 d = bus_rdata;
  endtask

  // Enable the transmitter and count cycles until completion; bounded
  task automatic tx_go(input logic [7:0] ctl1, output int n);
    wr(SCS_CTL1_OFS, ctl1);
    for (n = 0; n < 4000 && tx_irq !== 1'b1; n++) @(posedge clk_sys);
    if (n == 4000) begin
      error_cnt++;
      test_done();
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic sc_reset();
    rd(SCS_CTL1_OFS, s);
    // Buffer-empty flag reads one out of reset
    chk("ctl1 reset", s, SCS_CTL1_RST | (8'h01 << SCS_CTL1_TBE_BIT));
    @(posedge clk_sys);
    #1 chk("read data one cycle", bus_rdata, 8'h00);
    rd(SCS_MODE_OFS, s);
    chk("mode reset", s, SCS_MODE_RST);
    rd(3'h7, s);
    chk("unmapped read", s, 8'h00);
  endtask

  // Direct convention, held back while transmit is disabled
  task automatic sc_tx_direct();
    wr(SCS_MODE_OFS, 8'h65);
    wr(SCS_CTL0_OFS, 8'h10);
    wr(SCS_CTL1_OFS, 8'h10);
    wr(SCS_TXBUF_OFS, 8'h3B);
    repeat (40) begin
      @(posedge clk_sys);
      chk("no send while disabled", {7'h0, serial_out_pin}, 8'h01);
    end
    tx_go(8'h11, t_plain);
    repeat (40) @(posedge clk_sys);
    chk("one frame sent", 8'(u_scs_card.rx_cnt), 8'h01);
    chk("direct data order", u_scs_card.rx_bits[7:0], 8'h3B);
    chk("even parity", {7'h0, u_scs_card.rx_bits[8]}, 8'h01);
    rd(SCS_STAT_OFS, s);
    chk("tx status", s & 8'h7F, 8'h20);
    wr(SCS_STAT_OFS, 8'h77);
  endtask

  // Inverse convention with error signalling; card rejects the character
  task automatic sc_tx_inverse();
    u_scs_card.nak_en = 1'b1;
    wr(SCS_MODE_OFS, 8'h45);
    wr(SCS_CTL0_OFS, 8'h90);
    wr(SCS_CTL1_OFS, 8'hD0);
    wr(SCS_TXBUF_OFS, 8'h3B);
    tx_go(8'hD1, t_err);
    rd(SCS_STAT_OFS, s);
    chk("card error seen", s & 8'h7F, 8'h30);
    chk("late completion", 8'(t_err - t_plain), 8'h08);
    chk("inverse data order", u_scs_card.rx_bits[7:0], 8'h23);
    chk("odd parity", {7'h0, u_scs_card.rx_bits[8]}, 8'h00);
    repeat (80) @(posedge clk_sys);
    u_scs_card.nak_en = 1'b0;
    wr(SCS_STAT_OFS, 8'h77);
  endtask

  // Reception at divisor 1, refused while disabled, then overrun
  task automatic sc_rx_overrun();
    u_scs_card.bit_len = 32;
    wr(SCS_MODE_OFS, 8'h65);
    wr(SCS_CTL0_OFS, 8'h10);
    wr(SCS_BRG_OFS, 8'h01);
    wr(SCS_CTL1_OFS, 8'h00);
    u_scs_card.send_char({1'b0, 8'hA5});
    chk("no receive while disabled", {7'h0, rx_irq}, 8'h00);
    wr(SCS_CTL1_OFS, 8'h04);
    u_scs_card.send_char({1'b0, 8'hA5});
    rd(SCS_STAT_OFS, s);
    chk("rx request", s & 8'h7F, 8'h40);
    wr(SCS_STAT_OFS, 8'h40);
    u_scs_card.send_char({1'b0, 8'h5A});
    chk("rx request after overrun", {7'h0, rx_irq}, 8'h00);
    rd(SCS_STAT_OFS, s);
    chk("overrun and sum", s & 8'h7F, 8'h09);
    rd(SCS_RXBUF_OFS, s);
    chk("overwritten buffer", s, 8'h5A);
  endtask

  // Bad parity from the card with error signalling on
  task automatic sc_rx_parity();
    u_scs_card.bit_len = 16;
    wr(SCS_STAT_OFS, 8'h77);
    wr(SCS_BRG_OFS, 8'h00);
    wr(SCS_CTL1_OFS, 8'h84);
    u_scs_card.send_char({1'b1, 8'h0F});
    chk("error pulse on line", {7'h0, u_scs_card.err_seen}, 8'h01);
    rd(SCS_STAT_OFS, s);
    chk("parity and sum", s & 8'h0F, 8'h0C);
  endtask

  // Stop bit held low by the card: framing error, sum, character still kept
  task automatic sc_rx_framing();
    rd(SCS_RXBUF_OFS, s);
    wr(SCS_STAT_OFS, 8'h77);
    u_scs_card.bad_stop = 1'b1;
    u_scs_card.send_char({1'b0, 8'hA5});
    u_scs_card.bad_stop = 1'b0;
    rd(SCS_STAT_OFS, s);
    chk("framing and sum", s & 8'h0F, 8'h0A);
    rd(SCS_RXBUF_OFS, s);
    chk("framed data kept", s, 8'hA5);
  endtask

  // Slow prescaled sources, divide by 8 and by 32 with divisor 0
  task automatic sc_rx_slow();
    wr(SCS_STAT_OFS, 8'h77);
    wr(SCS_CTL1_OFS, 8'h04);
    wr(SCS_CTL0_OFS, 8'h11);
    u_scs_card.bit_len = 128;
    u_scs_card.send_char({1'b0, 8'hC3});
    rd(SCS_STAT_OFS, s);
    chk("div8 rx request", s & 8'h7F, 8'h40);
    rd(SCS_RXBUF_OFS, s);
    chk("div8 data", s, 8'hC3);
    wr(SCS_STAT_OFS, 8'h77);
    wr(SCS_CTL0_OFS, 8'h12);
    u_scs_card.bit_len = 512;
    u_scs_card.send_char({1'b0, 8'h3C});
    rd(SCS_STAT_OFS, s);
    chk("div32 rx request", s & 8'h7F, 8'h40);
    rd(SCS_RXBUF_OFS, s);
    chk("div32 data", s, 8'h3C);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    req = '0;
    error_cnt = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    sc_reset();
    sc_tx_direct();
    sc_tx_inverse();
    sc_rx_overrun();
    sc_rx_parity();
    sc_rx_framing();
    sc_rx_slow();
    test_done();
  end
endmodule
